// ### logic/full_closed_hybrid_deviation.sv
// full-closed loop feedback sums, hybrid deviation and excess fault
`timescale 1ns/10ps
`default_nettype none
`include "hybrid_defines.svh"
module full_closed_hybrid_deviation #(
	parameter int NUM_W = `NUM_W,
	parameter int DEN_W = `DEN_W,
	parameter int THR_W = `THR_W,
	parameter int CMD_W = `CMD_W
) (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     sys_rst,
	// feedback and command pulse pins
	input  wire logic                     enc_step,
	input  wire logic                     enc_dir,
	input  wire logic                     scl_step,
	input  wire logic                     scl_dir,
	input  wire logic                     cmd_step,
	input  wire logic                     cmd_dir,
	// stored settings, sampled once after power-up
	input  wire logic [CMD_W-1:0]         command_scaling_num,
	input  wire logic [CMD_W-1:0]         command_scaling_den,
	input  wire logic                     scale_direction_invert,
	input  wire logic [NUM_W-1:0]         scale_ratio_numerator,
	input  wire logic [`EXP_W-1:0]        scale_ratio_exponent,
	input  wire logic [DEN_W-1:0]         scale_ratio_denominator,
	input  wire logic [THR_W-1:0]         hybrid_excess_threshold,
	// status
	output logic                          settings_loaded_q,
	output hybrid_pkg::pos_t              enc_sum_q,
	output hybrid_pkg::pos_t              scl_sum_q,
	output hybrid_pkg::pos_t              cmd_pos_q,
	output hybrid_pkg::wide_t             hybrid_dev_q,
	output logic                          hybrid_excess_fault_q
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire  [`PIN_N-1:0] pin_w = {cmd_dir, cmd_step, scl_dir, scl_step, enc_dir, enc_step};
	logic [`PIN_N-1:0] lvl_q;
	logic [`PIN_N-1:0] lvl_prev_q;

	genvar gi;
	generate
		for (gi = 0; gi < `PIN_N; gi++) begin : g_sync
			logic [`SYNC_N-1:0] sh_q;
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst) begin
					sh_q <= '0;
					lvl_q[gi] <= 1'b0;
				end else begin
					sh_q <= {sh_q[`SYNC_N-2:0], pin_w[gi]};
					// a change counts only once stages two and three agree
					if (sh_q[1] == sh_q[2])
						lvl_q[gi] <= sh_q[2];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			lvl_prev_q <= '0;
		else
			lvl_prev_q <= lvl_q;
	end

	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction

	wire enc_ev = rise(lvl_q[`PIN_ENC_S], lvl_prev_q[`PIN_ENC_S]);
	wire scl_ev = rise(lvl_q[`PIN_SCL_S], lvl_prev_q[`PIN_SCL_S]);
	wire cmd_ev = rise(lvl_q[`PIN_CMD_S], lvl_prev_q[`PIN_CMD_S]);

	// ----------------------------------------
	// power-on settings capture
	// ----------------------------------------
	// taken once at the first edge after reset; later writes wait for power-up
	logic [CMD_W-1:0]  cnum_q;
	logic [CMD_W-1:0]  cden_q;
	logic              inv_q;
	logic [NUM_W-1:0]  num_q;
	logic [`EXP_W-1:0] exp_q;
	logic [DEN_W-1:0]  den_q;
	logic [THR_W-1:0]  thr_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			settings_loaded_q <= 1'b0;
			cnum_q <= '0;
			cden_q <= '0;
			inv_q  <= 1'b0;
			num_q  <= '0;
			exp_q  <= '0;
			den_q  <= '0;
			thr_q  <= '0;
		end else if (!settings_loaded_q) begin
			settings_loaded_q <= 1'b1;
			cnum_q <= command_scaling_num;
			cden_q <= command_scaling_den;
			inv_q  <= scale_direction_invert;
			num_q  <= scale_ratio_numerator;
			exp_q  <= scale_ratio_exponent;
			den_q  <= scale_ratio_denominator;
			thr_q  <= hybrid_excess_threshold;
		end
	end

	// ----------------------------------------
	// feedback sums
	// ----------------------------------------
	wire enc_up = lvl_q[`PIN_ENC_D];
	wire scl_up = lvl_q[`PIN_SCL_D] ^ inv_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			enc_sum_q <= `POS_RST;
			scl_sum_q <= `POS_RST;
		end else begin
			if (enc_ev)
				enc_sum_q <= enc_up ? enc_sum_q + 1'b1 : enc_sum_q - 1'b1;
			if (scl_ev)
				scl_sum_q <= scl_up ? scl_sum_q + 1'b1 : scl_sum_q - 1'b1;
		end
	end

	// ----------------------------------------
	// command scaling
	// ----------------------------------------
	logic cmd_out;
	logic cmd_out_dir;

	ratio_scaler #(
		.W (CMD_W)
	) u_cmd_scale (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_pulse  (cmd_ev && settings_loaded_q),
		.in_dir    (lvl_q[`PIN_CMD_D]),
		.num       (cnum_q),
		.den       (cden_q),
		.out_pulse (cmd_out),
		.out_dir   (cmd_out_dir)
	);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			cmd_pos_q <= `POS_RST;
		else if (cmd_out)
			cmd_pos_q <= cmd_out_dir ? cmd_pos_q + 1'b1 : cmd_pos_q - 1'b1;
	end

	// ----------------------------------------
	// hybrid deviation
	// ----------------------------------------
	// both sides are multiplied by den so no divider is needed;
	// the deviation output is therefore in scale pulses times den
	wire signed [`POS_W+NUM_W:0] enc_prod = enc_sum_q * $signed({1'b0, num_q});
	wire signed [`POS_W+DEN_W:0] scl_prod = scl_sum_q * $signed({1'b0, den_q});
	wire hybrid_pkg::wide_t enc_term = hybrid_pkg::wide_t'(enc_prod) <<< exp_q;
	wire hybrid_pkg::wide_t scl_term = hybrid_pkg::wide_t'(scl_prod);
	wire hybrid_pkg::wide_t dev_d    = enc_term - scl_term;
	wire hybrid_pkg::mag_t  dev_abs  = hybrid_dev_q[`WIDE_W-1] ? -hybrid_dev_q : hybrid_dev_q;
	wire [THR_W+`THR_SHIFT-1:0] thr_pulses = {thr_q, {`THR_SHIFT{1'b0}}};
	// widened before the product so no bit of threshold times den is lost
	wire hybrid_pkg::mag_t  limit    = hybrid_pkg::mag_t'(thr_pulses) * hybrid_pkg::mag_t'(den_q);
	wire over = settings_loaded_q && (dev_abs > limit);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hybrid_dev_q          <= '0;
			hybrid_excess_fault_q <= 1'b0;
		end else begin
			hybrid_dev_q <= dev_d;
			// latched: only a reset (power cycle) clears it
			if (over)
				hybrid_excess_fault_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_fault_sticky: assert property (hybrid_excess_fault_q |=> hybrid_excess_fault_q)
		else $error("excess fault dropped without reset");
	a_fault_raise: assert property (over |=> hybrid_excess_fault_q)
		else $error("excess not flagged");
	a_fault_cause: assert property ($rose(hybrid_excess_fault_q) |-> $past(over))
		else $error("fault raised without excess");
	a_enc_count: assert property (enc_ev |=>
		enc_sum_q == $past(enc_sum_q) + ($past(enc_up) ? 32'sh1 : -32'sh1))
		else $error("encoder sum step wrong");
	a_scl_invert: assert property (scl_ev |=>
		scl_sum_q == $past(scl_sum_q) + (($past(lvl_q[`PIN_SCL_D]) ^ inv_q) ? 32'sh1 : -32'sh1))
		else $error("scale sum direction wrong");
	a_sums_hold: assert property (!enc_ev && !scl_ev |=> $stable(enc_sum_q) && $stable(scl_sum_q))
		else $error("sum moved without pulse");
	a_settings_frozen: assert property (settings_loaded_q |=>
		$stable(num_q) && $stable(den_q) && $stable(exp_q) && $stable(thr_q) && $stable(inv_q))
		else $error("settings changed after power-up");
	a_dev_zero: assert property (enc_sum_q == 0 && scl_sum_q == 0 |=> hybrid_dev_q == 0)
		else $error("deviation nonzero at zero position");
	a_cmd_step: assert property (cmd_out |=> cmd_pos_q != $past(cmd_pos_q))
		else $error("scaled command pulse lost");

	c_fault: cover property ($rose(hybrid_excess_fault_q));
	c_cmd: cover property (cmd_ev ##[1:4] cmd_out);
	c_both: cover property (enc_ev ##[1:20] scl_ev);
endmodule : full_closed_hybrid_deviation
`default_nettype wire

// ### include/hybrid_defines.svh
// constants for the full-closed hybrid deviation block
`ifndef HYBRID_DEFINES_SVH
`define HYBRID_DEFINES_SVH
`define POS_W       32
`define WIDE_W      80
`define NUM_W       16
`define EXP_W       5
`define DEN_W       16
`define THR_W       16
`define THR_SHIFT   4
`define CMD_W       16
`define SYNC_N      3
`define PIN_N       6
`define PIN_ENC_S   0
`define PIN_ENC_D   1
`define PIN_SCL_S   2
`define PIN_SCL_D   3
`define PIN_CMD_S   4
`define PIN_CMD_D   5
`define POS_RST     32'h0000_0000
`endif

// ### include/hybrid_pkg.sv
// shared types for the full-closed hybrid deviation block
`include "hybrid_defines.svh"
package hybrid_pkg;
	typedef logic signed [`POS_W-1:0]  pos_t;
	typedef logic signed [`WIDE_W-1:0] wide_t;
	typedef logic [`WIDE_W-1:0]        mag_t;
endpackage : hybrid_pkg

// ### logic/ratio_scaler.sv
// pulse-rate scaler: out rate = in rate * num / den; den 0 bypasses, out rate = in rate
`timescale 1ns/10ps
`default_nettype none
`include "hybrid_defines.svh"
module ratio_scaler #(
	parameter int W = `CMD_W
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// incoming pulse stream
	input  wire logic         in_pulse,
	input  wire logic         in_dir,
	// ratio
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	// scaled stream
	output logic              out_pulse,
	output logic              out_dir
);
	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	// pending credit drains one pulse per cycle; input rate is far below mclk
	logic [W+1:0] acc_q;
	logic [W+1:0] acc_d;
	logic         dir_q;
	wire          bypass = (den == '0);
	wire  [W+1:0] den_w  = {2'b00, den};
	wire  [W+1:0] num_w  = {2'b00, num};
	wire          drain  = !bypass && (acc_q >= den_w);
	wire  [W+1:0] after  = drain ? acc_q - den_w : acc_q;

	assign acc_d = (in_pulse && !bypass) ? after + num_w : after;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_q     <= '0;
			dir_q     <= 1'b0;
			out_pulse <= 1'b0;
			out_dir   <= 1'b0;
		end else begin
			acc_q     <= acc_d;
			if (in_pulse)
				dir_q <= in_dir;
			out_pulse <= bypass ? in_pulse : drain;
			out_dir   <= bypass ? in_dir : dir_q;
		end
	end
endmodule : ratio_scaler
`default_nettype wire

// ### verif/pulse_source.sv
// partner model: encoder, external scale and host pulse sources
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
	// clock
	input  wire logic       mclk,
	// burst request, counts and directions
	input  wire logic       go,
	input  wire logic [7:0] n_e,
	input  wire logic [7:0] n_s,
	input  wire logic [7:0] n_c,
	input  wire logic [2:0] sd,
	// pins: 0 encoder, 1 scale, 2 command
	output logic      [2:0] step,
	output logic      [2:0] dir,
	output logic            done
);
	// ------------------------------------------------------------------
	// one channel burst, direction settled well before the first step
	// ------------------------------------------------------------------
	task burst(input int ch, input logic [7:0] n, input logic d);
		dir[ch] <= d;
		repeat (4) @(posedge mclk);
		repeat (n) begin
			step[ch] <= 1'b1;
			repeat (3) @(posedge mclk);
			step[ch] <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask : burst

	initial begin
		{step, dir, done} = '0;
		forever begin
			@(posedge mclk);
			if (go === 1'b1) begin
				burst(0, n_e, sd[0]);
				burst(1, n_s, sd[1]);
				burst(2, n_c, sd[2]);
				// slack for sync, scaling drain and fault latch
				repeat (16) @(posedge mclk);
				done <= 1'b1;
				@(posedge mclk);
				done <= 1'b0;
			end
		end
	end
endmodule : pulse_source
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the hybrid deviation block
`timescale 1ns/10ps
`default_nettype none
`include "hybrid_defines.svh"
module testbench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	typedef struct {hybrid_pkg::pos_t e, s, c; hybrid_pkg::wide_t d; logic f;} note_t;
	logic              mclk, sys_rst, go, inv, done, loaded, fault;
	logic [15:0]       cnum, cden, num, den, thr;
	logic [`EXP_W-1:0] ex;
	logic [7:0]        n_e, n_s, n_c;
	logic [2:0]        sd, step, dir;
	logic [31:0]       r;
	logic [31:0]       seed = 32'h0000_0002;
	hybrid_pkg::pos_t  enc_sum, scl_sum, cmd_pos;
	hybrid_pkg::wide_t dev;
	note_t             q[$];
	note_t             m;
	int                err_total, tests_run;

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	full_closed_hybrid_deviation DUT (.mclk(mclk), .sys_rst(sys_rst),
		.enc_step(step[0]), .enc_dir(dir[0]), .scl_step(step[1]), .scl_dir(dir[1]),
		.cmd_step(step[2]), .cmd_dir(dir[2]), .command_scaling_num(cnum),
		.command_scaling_den(cden), .scale_direction_invert(inv),
		.scale_ratio_numerator(num), .scale_ratio_exponent(ex),
		.scale_ratio_denominator(den), .hybrid_excess_threshold(thr),
		.settings_loaded_q(loaded), .enc_sum_q(enc_sum), .scl_sum_q(scl_sum),
		.cmd_pos_q(cmd_pos), .hybrid_dev_q(dev), .hybrid_excess_fault_q(fault));

	pulse_source partner (.mclk(mclk), .go(go), .n_e(n_e), .n_s(n_s), .n_c(n_c),
		.sd(sd), .step(step), .dir(dir), .done(done));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function hybrid_pkg::wide_t mag(input hybrid_pkg::wide_t v);
		return (v < 0) ? -v : v;
	endfunction : mag

	task check(input hybrid_pkg::wide_t seen, input hybrid_pkg::wide_t want);
		tests_run++;
		if (seen !== want) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// power cycle, load settings, scramble them, run one burst per channel
	task run_case(input logic i, input logic [15:0] nu, input logic [4:0] xp,
		input logic [15:0] de, th, cn, cd, input logic [7:0] ne, ns, nc,
		input logic [2:0] dr);
		hybrid_pkg::wide_t k, wd, lim;
		hybrid_pkg::pos_t  e, s;
		note_t             x;
		int                w;
		k = nu;
		k = k << xp;
		wd = de;
		lim = th;
		lim = lim * wd * 16;
		e = dr[0] ? ne : -ne;
		s = (dr[1] ^ i) ? ns : -ns;
		x.e = e;
		x.s = s;
		x.c = (cd == 16'h0000) ? nc : nc * cn / cd;
		if (!dr[2]) x.c = -x.c;
		x.d = e * k - s * wd;
		// sticky fault: worst point is end of encoder phase or the end
		x.f = (mag(x.d) > lim) || (mag(e * k) > lim);
		@(posedge mclk);
		sys_rst <= 1'b1;
		{inv, num, ex, den, thr, cnum, cden} <= {i, nu, xp, de, th, cn, cd};
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		w = 0;
		while (loaded !== 1'b1 && w < 20) begin
			@(posedge mclk);
			w++;
		end
		if (loaded !== 1'b1)
			err_total++;
		{inv, num, ex, den, thr, cnum, cden} <= 86'({rnd(), rnd(), rnd()});
		{n_e, n_s, n_c, sd} <= {ne, ns, nc, dr};
		q.push_back(x);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		w = 0;
		while (done !== 1'b1 && w < 3000) begin
			@(posedge mclk);
			w++;
		end
		if (done !== 1'b1)
			err_total++;
	endtask : run_case

	// ------------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (done === 1'b1 && q.size() > 0) begin
			m = q.pop_front();
			check(loaded, 1'b1);
			check(enc_sum, m.e);
			check(scl_sum, m.s);
			check(cmd_pos, m.c);
			check(dev, m.d);
			check(fault, m.f);
		end
	end

	// ------------------------------------------------------------------
	// main sequence; ratios all stay within 1/20..20
	// ------------------------------------------------------------------
	initial begin
		{go, inv, num, ex, den, thr, cnum, cden, n_e, n_s, n_c, sd} = '0;
		sys_rst = 1'b1;
		run_case(1'h0, 16'h1, 5'h0, 16'h1, 16'hFF, 16'h2, 16'h1, 8'hA, 8'hA, 8'h3, 3'h7);
		run_case(1'h1, 16'h1, 5'h0, 16'h1, 16'hFF, 16'h0, 16'h0, 8'h5, 8'h5, 8'h4, 3'h1);
		run_case(1'h0, 16'h3, 5'h1, 16'h4, 16'hFF, 16'h3, 16'h2, 8'h4, 8'h6, 8'h4, 3'h7);
		run_case(1'h0, 16'h1, 5'h4, 16'h10, 16'hFF, 16'h1, 16'h1, 8'h3, 8'h3, 8'h2, 3'h3);
		run_case(1'h0, 16'h1, 5'h0, 16'h1, 16'h1, 16'h1, 16'h1, 8'h10, 8'h0, 8'h0, 3'h7);
		run_case(1'h0, 16'h1, 5'h0, 16'h1, 16'h1, 16'h1, 16'h1, 8'h11, 8'h0, 8'h0, 3'h7);
		run_case(1'h0, 16'h1, 5'h0, 16'h1, 16'h1, 16'h1, 16'h1, 8'h0, 8'h11, 8'h0, 3'h7);
		run_case(1'h0, 16'h1, 5'h1, 16'h2, 16'h1, 16'h1, 16'h1, 8'h11, 8'h0, 8'h0, 3'h7);
		for (int n = 0; n < 4; n++) begin
			r = rnd();
			run_case(r[0], 16'h1, 5'h0, 16'h1, 16'hFFFF, 16'h1, 16'h1, {4'h0, r[7:4]},
				{4'h0, r[11:8]}, {4'h0, r[15:12]}, r[18:16]);
		end
		finish_test;
	end

	// hang guard, at least eight times the expected run
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		finish_test;
	end
endmodule : testbench
`default_nettype wire
